// *** design/ssr_pkg.sv ***
// Package of constants for the standstill release controller
package ssr_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses, word index taken from haddr[5:2])
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_CTRL = 4'h0;    // 0x00 configuration
  localparam logic [3:0] IDX_THRESH = 4'h1;  // 0x04 threshold and hysteresis
  localparam logic [3:0] IDX_STATUS = 4'h2;  // 0x08 live state, read only
  localparam logic [3:0] IDX_FREQ = 4'h3;    // 0x0c measured frequency, read only
  // CTRL fields
  localparam int CTRL_MANUAL = 0;   // 1: manual rearm, 0: automatic
  localparam int CTRL_CLR_EN = 1;   // 1: clear input in use
  localparam int CTRL_MODE_LO = 2;  // override mode, 2 bits
  localparam int CTRL_TLIM = 4;     // 1: override time limit on
  localparam int CTRL_DEB = 5;      // 1: 350 ms debounce, 0: 100 ms
  localparam logic [5:0] CTRL_RST = 6'h11;  // manual rearm, time limit on
  // THRESH fields: threshold in 0.01 Hz steps, hysteresis in percent
  localparam int THR_W = 14;
  localparam int HYS_LO = 16;
  localparam int HYS_W = 7;
  localparam logic [13:0] THR_MIN = 14'h000a;  // 0.10 Hz
  localparam logic [13:0] THR_MAX = 14'h26ac;  // 99.00 Hz
  localparam logic [13:0] THR_RST = 14'h0064;  // 1.00 Hz
  localparam logic [6:0] HYS_MAX = 7'h32;      // 50 percent
  localparam logic [6:0] HYS_RST = 7'h0a;      // 10 percent
  localparam logic [6:0] PCT_FULL = 7'h64;     // 100 percent
  // Override modes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_MUTE = 2'h1;
  localparam logic [1:0] MODE_BYPASS = 2'h2;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 25000;                  // 40 MHz
  localparam int MS_PS = 1000000000;
  localparam int CYC_PER_MS = MS_PS / CLK_PERIOD_PS;    // timebase tick
  localparam int MS_W = 15;
  localparam logic [14:0] DEB_SHORT_MS = 15'd100;
  localparam logic [14:0] DEB_LONG_MS = 15'd350;
  localparam logic [14:0] PULSE_MAX_MS = 15'd30000;
  localparam logic [14:0] FLASH_HALF_MS = 15'd500;      // 1 Hz blink
  localparam logic [14:0] OVR_LIMIT_MS = 15'd1000;
endpackage

// *** design/ssr_top.sv ***
// Standstill release controller with rearm, clear and override handling
//
// Chosen here: the register addresses and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none

module ssr_top
  import ssr_pkg::*;
#(
  parameter int FREQ_W = 18,                 // measured frequency width, 0.01 Hz units
  parameter int P_CYC_PER_MS = CYC_PER_MS    // clock cycles per timebase tick
) (
  input wire logic hclk,                     // bus and block clock
  input wire logic hresetn,                  // asynchronous reset, low active
  input wire logic ce,                       // clock enable, low freezes state
  input wire logic hsel,                     // slave select
  input wire logic [31:0] haddr,             // byte address
  input wire logic [1:0] htrans,             // transfer type
  input wire logic hwrite,                   // write strobe
  input wire logic [2:0] hsize,              // transfer size
  input wire logic [31:0] hwdata,            // write data
  input wire logic hready,                   // bus ready in
  output logic hreadyout,                    // slave ready
  output logic hresp,                        // response, always OKAY
  output logic [31:0] hrdata,                // read data
  input wire logic rearm_pin,                // operator rearm button
  input wire logic clear_pin,                // operator clear button
  input wire logic override_pin,             // bypass or mute switch
  input wire logic [FREQ_W-1:0] freq_meas,   // measured sensor frequency
  input wire logic freq_valid,               // measurement is valid
  input wire logic err_cutoff_in,            // cut-off frequency fault seen
  input wire logic err_sensor_in,            // sensor fault seen
  input wire logic err_discrep_in,           // discrepancy fault seen
  input wire logic warn_vib_in,              // vibration warning cause
  input wire logic warn_phase_in,            // phase warning cause
  output logic grant,                        // release output, low is safe
  output logic rearm_req,                    // rearm request indicator
  output logic clear_req,                    // clear request indicator
  output logic err_cutoff,                   // sticky cut-off error
  output logic err_sensor,                   // sticky sensor error
  output logic err_discrep,                  // sticky discrepancy error
  output logic warn_vib,                     // vibration warning
  output logic warn_phase,                   // phase warning
  output logic override_active               // bypass or mute in force
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  // The tick divider needs two cycles at least; the comparator needs the
  // whole threshold width, and the hysteresis product must fit 32 bits
  localparam int PRE_W = $clog2(P_CYC_PER_MS + 1);
  generate
    if (P_CYC_PER_MS < 2 || FREQ_W < THR_W || FREQ_W > 24) begin : g_bad
      $error("ssr_top: unsupported parameter value");
    end
  endgenerate

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Runtime state: everything that a clear without override wipes, bar the prescaler.
  // Configuration and bus state sit outside it and survive a clear.
  typedef struct packed {
    logic [PRE_W-1:0] presc;     // timebase prescaler
    logic tick;                  // one-cycle ms tick
    logic [MS_W-1:0] flash_cnt;  // blink half period counter
    logic flash;                 // 1 Hz blink phase
    logic [1:0][MS_W-1:0] pcnt;  // high time of rearm and clear pulses
    logic [1:0] plow;            // pin seen low, pulse may start
    logic [2:0] prev;            // last synchronised pin levels
    logic ovr_armed;             // override pin has been low
    logic ovr_act;               // override in force
    logic [MS_W-1:0] ovr_cnt;    // override time used
    logic speed_ok;              // below hysteresis, not yet over threshold
    logic rearm_ok;              // rearm confirmed
    logic grant;
    logic rearm_req;
    logic clear_req;
    logic [2:0] err;             // cut-off, sensor, discrepancy
    logic [1:0] warn;            // vibration, phase
  } ssr_rt_t;

  typedef struct packed {
    logic [2:0] s1;              // first synchroniser stage
    logic [2:0] s2;              // second synchroniser stage
    logic hreadyout;
    logic hresp;                 // always OKAY, held in a flop
    logic [31:0] hrdata;
    logic dsel;                  // data phase pending
    logic dwr;
    logic [3:0] didx;
    logic [5:0] ctrl;
    logic [THR_W-1:0] thr;
    logic [HYS_W-1:0] hys;
    ssr_rt_t rt;
  } ssr_state_t;

  // Runtime value after a full clear; live inputs are patched in below
  localparam ssr_rt_t RT_RST = '0;

  ssr_state_t q;
  ssr_state_t next_q;

  // ----------------------------------------------------------------
  // Derived terms
  // ----------------------------------------------------------------
  logic [2:0] pin_now;
  logic [2:0] rise;
  logic [2:0] fall;
  logic [1:0] pulse_ok;
  logic [MS_W-1:0] deb_ms;
  logic over_thr;
  logic under_hys;
  logic manual;
  logic [1:0] mode;
  logic err_any;

  // Edges of the synchronised pins, in the same cycle as the second stage changes
  assign pin_now = q.s2;
  assign rise = pin_now & ~q.rt.prev;
  assign fall = ~pin_now & q.rt.prev;
  assign manual = q.ctrl[CTRL_MANUAL];
  assign mode = q.ctrl[CTRL_MODE_LO +: 2];
  assign err_any = |q.rt.err;
  assign deb_ms = q.ctrl[CTRL_DEB] ? DEB_LONG_MS : DEB_SHORT_MS;

  // Comparator on the measured value; the measurement sets the
  // detection time, this stage adds one cycle
  // Products are formed at 32 bits, so no overflow can occur
  assign over_thr = freq_meas >= FREQ_W'(q.thr);
  assign under_hys = (32'(freq_meas) * 32'(PCT_FULL))
                     < (32'(q.thr) * 32'(PCT_FULL - q.hys));

  // Low-high-low pulse check for rearm (0) and clear (1)
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pulse
      assign pulse_ok[gi] = fall[gi] && q.rt.plow[gi]
                            && (q.rt.pcnt[gi] > deb_ms)
                            && (q.rt.pcnt[gi] < PULSE_MAX_MS);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic rearm_valid;
    logic clear_valid;
    logic ovr_end;
    logic [THR_W-1:0] wthr;
    logic [HYS_W-1:0] whys;
    rearm_valid = 1'b0;
    clear_valid = 1'b0;
    ovr_end = 1'b0;
    wthr = '0;
    whys = '0;
    next_q = q;

    // Pin synchronisers: the operator pins are asynchronous, so only
    // the second stage feeds the edge detectors
    next_q.s1 = {override_pin, clear_pin, rearm_pin};
    next_q.s2 = q.s1;
    next_q.rt.prev = pin_now;

    // Bus address phase: latch transfer, prepare read data
    // Zero wait states: read data stand for the whole data phase
    // A read right behind a write to the same register sees the old value
    next_q.hreadyout = 1'b1;
    next_q.dsel = 1'b0;
    if (hsel && hready && htrans[1]) begin
      next_q.dsel = 1'b1;
      next_q.dwr = hwrite;
      next_q.didx = haddr[5:2];
      next_q.hrdata = '0;
      if (!hwrite) begin
        unique case (haddr[5:2])
          IDX_CTRL: next_q.hrdata[5:0] = q.ctrl;
          IDX_THRESH: begin
            next_q.hrdata[THR_W-1:0] = q.thr;
            next_q.hrdata[HYS_LO +: HYS_W] = q.hys;
          end
          IDX_STATUS: next_q.hrdata[12:0] = {q.rt.speed_ok, q.rt.rearm_ok,
                                             q.rt.ovr_act, q.rt.warn, q.rt.err,
                                             q.rt.clear_req, q.rt.rearm_req,
                                             q.rt.grant, freq_valid, q.rt.flash};
          IDX_FREQ: next_q.hrdata[FREQ_W-1:0] = freq_meas;
          default: next_q.hrdata = '0;
        endcase
      end
    end

    // Bus data phase: writes, clamped to the legal ranges
    if (q.dsel && q.dwr) begin
      unique case (q.didx)
        IDX_CTRL: next_q.ctrl = hwdata[5:0];
        IDX_THRESH: begin
          wthr = hwdata[THR_W-1:0];
          whys = hwdata[HYS_LO +: HYS_W];
          next_q.thr = (wthr < THR_MIN) ? THR_MIN
                       : (wthr > THR_MAX) ? THR_MAX : wthr;
          next_q.hys = (whys > HYS_MAX) ? HYS_MAX : whys;
        end
        default: ;
      endcase
    end

    // Millisecond timebase and 1 Hz blink
    // The prescaler runs free, but a clear without override holds its count for one cycle, so the next tick comes one cycle late
    next_q.rt.tick = 1'b0;
    if (q.rt.presc == PRE_W'(P_CYC_PER_MS - 1)) begin
      next_q.rt.presc = '0;
      next_q.rt.tick = 1'b1;
    end else begin
      next_q.rt.presc = q.rt.presc + 1'b1;
    end
    if (q.rt.tick) begin
      if (q.rt.flash_cnt == FLASH_HALF_MS - 1'b1) begin
        next_q.rt.flash_cnt = '0;
        next_q.rt.flash = ~q.rt.flash;
      end else begin
        next_q.rt.flash_cnt = q.rt.flash_cnt + 1'b1;
      end
    end

    // Pulse high-time counters, saturating above the longest pulse
    // Saturation stops a held button from wrapping into a valid width
    for (int i = 0; i < 2; i++) begin
      if (!pin_now[i]) begin
        next_q.rt.pcnt[i] = '0;
        next_q.rt.plow[i] = 1'b1;
      end else if (q.rt.tick && q.rt.pcnt[i] != PULSE_MAX_MS) begin
        next_q.rt.pcnt[i] = q.rt.pcnt[i] + 1'b1;
      end
    end
    rearm_valid = pulse_ok[0] && manual;
    clear_valid = pulse_ok[1] && q.ctrl[CTRL_CLR_EN];

    // Warnings follow their cause, errors latch
    next_q.rt.warn = {warn_phase_in, warn_vib_in};
    next_q.rt.err = q.rt.err | {err_discrep_in, err_sensor_in, err_cutoff_in};

    // Override: fresh rising edge only, mode decides the condition
    // A mode change to off ends an active override like a pin fall
    // The time limit counts only while enabled
    if (!pin_now[2]) begin
      next_q.rt.ovr_armed = 1'b1;
    end
    if (q.rt.ovr_act) begin
      if (q.rt.tick && q.ctrl[CTRL_TLIM]) begin
        next_q.rt.ovr_cnt = q.rt.ovr_cnt + 1'b1;
      end
      if (fall[2] || mode == MODE_OFF
          || (q.ctrl[CTRL_TLIM] && q.rt.ovr_cnt >= OVR_LIMIT_MS)) begin
        ovr_end = 1'b1;
      end
    end else if (rise[2] && q.rt.ovr_armed) begin
      if (mode == MODE_BYPASS || (mode == MODE_MUTE && q.rt.grant)) begin
        next_q.rt.ovr_act = 1'b1;
        next_q.rt.ovr_cnt = '0;
      end
    end
    if (ovr_end) begin
      next_q.rt.ovr_act = 1'b0;
      next_q.rt.err = {err_discrep_in, err_sensor_in, err_cutoff_in};
    end

    // Speed window with hysteresis
    // Between the two thresholds the last decision holds
    if (!freq_valid || over_thr) begin
      next_q.rt.speed_ok = 1'b0;
    end else if (under_hys) begin
      next_q.rt.speed_ok = 1'b1;
    end

    // Rearm interlock: set when the grant is lost, not during override
    // A pulse taken during an override still counts after it ends
    if (!q.rt.ovr_act && (!q.rt.speed_ok || err_any || !freq_valid)) begin
      next_q.rt.rearm_ok = 1'b0;
    end
    if (rearm_valid) begin
      next_q.rt.rearm_ok = 1'b1;
    end

    // Grant
    // Override forces it; otherwise all conditions must hold together
    if (q.rt.ovr_act) begin
      next_q.rt.grant = 1'b1;
    end else begin
      next_q.rt.grant = freq_valid && q.rt.speed_ok && !err_any
                        && (!manual || q.rt.rearm_ok);
    end

    // Indicators
    // Both blink from the same phase, so they flash together
    next_q.rt.rearm_req = manual && !q.rt.rearm_ok && q.rt.flash;
    next_q.rt.clear_req = q.ctrl[CTRL_CLR_EN] && err_any && q.rt.flash;

    // Clear pulse: errors only under override, else the runtime state
    if (clear_valid) begin
      if (q.rt.ovr_act) begin
        next_q.rt.err = {err_discrep_in, err_sensor_in, err_cutoff_in};
        next_q.rt.clear_req = 1'b0;
      end else begin
        next_q.rt = RT_RST;
        // Live causes win over the clear, so a persisting error sets again
        next_q.rt.err = {err_discrep_in, err_sensor_in, err_cutoff_in};
        next_q.rt.warn = {warn_phase_in, warn_vib_in};
        next_q.rt.presc = q.rt.presc;
        next_q.rt.prev = pin_now;
        next_q.rt.plow = ~pin_now[1:0];
        next_q.rt.ovr_armed = ~pin_now[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Clock enable low freezes every flop, bus and synchronisers too
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.hreadyout <= 1'b1;
      q.ctrl <= CTRL_RST;
      q.thr <= THR_RST;
      q.hys <= HYS_RST;
    end else if (ce) begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hreadyout = q.hreadyout;
  // Response flop resets to OKAY and is never changed
  assign hresp = q.hresp;
  assign hrdata = q.hrdata;
  assign grant = q.rt.grant;
  assign rearm_req = q.rt.rearm_req;
  assign clear_req = q.rt.clear_req;
  assign err_cutoff = q.rt.err[0];
  assign err_sensor = q.rt.err[1];
  assign err_discrep = q.rt.err[2];
  assign warn_vib = q.rt.warn[0];
  assign warn_phase = q.rt.warn[1];
  assign override_active = q.rt.ovr_act;

endmodule // ssr_top

`default_nettype wire

// *** verif/ssr_partner.sv ***
// Operator button and switch model for the release controller
`timescale 1ns/10ps
`default_nettype none
module ssr_partner #(
  parameter int P = 2
) (
  input wire logic hclk,     // block clock
  output logic rearm_pin,    // rearm button
  output logic clear_pin,    // clear button
  output logic override_pin  // bypass or mute switch
);
  // Released buttons fall back to their pull-down level
  initial begin
    rearm_pin = 1'b0;
    clear_pin = 1'b0;
    override_pin = 1'b0;
  end
  // Low-high-low press held for ms milliseconds
  task automatic press(input int which, input int ms);
    @(posedge hclk);
    rearm_pin <= (which == 0);
    clear_pin <= (which != 0);
    repeat (ms * P) @(posedge hclk);
    rearm_pin <= 1'b0;
    clear_pin <= 1'b0;
  endtask
  // Move the override switch
  task automatic flip(input logic v);
    @(posedge hclk);
    override_pin <= v;
  endtask
endmodule // ssr_partner
`default_nettype wire

// *** verif/ssr_asserts.sv ***
// Port checker for the release controller
`timescale 1ns/10ps
`default_nettype none
module ssr_asserts #(
  parameter int P_CYC_PER_MS = 2
) (
  input wire logic hclk,            // clock
  input wire logic hresetn,         // reset
  input wire logic hreadyout,       // ready
  input wire logic hresp,           // response
  input wire logic freq_valid,      // data valid
  input wire logic override_pin,    // switch
  input wire logic err_cutoff_in,   // fault cause
  input wire logic warn_vib_in,     // warning cause
  input wire logic warn_phase_in,   // warning cause
  input wire logic grant,           // release
  input wire logic rearm_req,       // rearm blink
  input wire logic err_cutoff,      // error
  input wire logic err_sensor,      // error
  input wire logic err_discrep,     // error
  input wire logic warn_vib,        // warning
  input wire logic warn_phase,      // warning
  input wire logic override_active  // override
);
  localparam int HALF = 500 * P_CYC_PER_MS;
  localparam int LIM = 1000 * P_CYC_PER_MS + 8;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic any_err;
  int hi_cnt;
  int ovr_cnt;
  assign any_err = err_cutoff | err_sensor | err_discrep;
  // Lengths of the blink high phase and of the override
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hi_cnt <= 0;
      ovr_cnt <= 0;
    end else begin
      hi_cnt <= rearm_req ? hi_cnt + 1 : 0;
      ovr_cnt <= override_active ? ovr_cnt + 1 : 0;
    end
  end
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_invalid_safe: assert property ((!freq_valid && !override_active) [*3] |-> !grant)
    else $error("grant with invalid data");
  a_error_safe: assert property ((any_err && !override_active) [*3] |-> !grant)
    else $error("grant with error");
  a_error_latch: assert property (err_cutoff_in |-> ##[1:2] err_cutoff)
    else $error("error not shown");
  a_warn_rise: assert property (warn_vib_in |=> warn_vib)
    else $error("warning not shown");
  a_warn_drop: assert property (!warn_phase_in |=> !warn_phase)
    else $error("warning not dropped");
  a_ovr_holds: assert property (override_active [*2] |-> grant)
    else $error("override without grant");
  a_ovr_pin_end: assert property (!override_pin [*6] |-> !override_active)
    else $error("override outlives switch");
  a_flash_half: assert property (hi_cnt <= HALF)
    else $error("blink half period too long");
  a_time_limit: assert property (ovr_cnt <= LIM)
    else $error("override time limit missed");
  c_grant: cover property ($rose(grant));
  c_override: cover property ($rose(override_active));
  c_cleared: cover property ($fell(err_sensor));
endmodule // ssr_asserts
bind ssr_top ssr_asserts #(.P_CYC_PER_MS(P_CYC_PER_MS)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .freq_valid(freq_valid), .override_pin(override_pin), .err_cutoff_in(err_cutoff_in),
  .warn_vib_in(warn_vib_in), .warn_phase_in(warn_phase_in), .grant(grant),
  .rearm_req(rearm_req), .err_cutoff(err_cutoff), .err_sensor(err_sensor),
  .err_discrep(err_discrep), .warn_vib(warn_vib), .warn_phase(warn_phase),
  .override_active(override_active));
`default_nettype wire

// *** verif/standstill_release_control_tb_top.sv ***
// Self-checking testbench of the release controller
`timescale 1ns/10ps
`default_nettype none
module standstill_release_control_tb_top import ssr_pkg::*;;
  localparam int P = 2;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic ce = 1'b1;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic [17:0] freq = 18'h0;
  logic fvalid = 1'b0;
  logic [2:0] errs = 3'h0;
  logic [1:0] warns = 2'h0;
  logic dph_rd = 1'b0;
  logic [31:0] qm[$];
  logic [31:0] qe[$];
  logic [17:0] ft[5] = '{18'd1000, 18'd950, 18'd899, 18'd999, 18'd1000};
  logic [4:0] gt = 5'b01100;
  int num_errors = 0;
  int checks = 0;
  int seed = 49241;
  int n;
  wire logic hreadyout, hresp, rearm_pin, clear_pin, override_pin;
  wire logic grant, rearm_req, clear_req, override_active;
  wire logic [31:0] hrdata;
  wire logic [2:0] eo;
  wire logic [1:0] wo;
  always #12.5 hclk = ~hclk;
  ssr_top #(.P_CYC_PER_MS(P)) u_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .rearm_pin(rearm_pin), .clear_pin(clear_pin),
    .override_pin(override_pin), .freq_meas(freq), .freq_valid(fvalid),
    .err_cutoff_in(errs[0]), .err_sensor_in(errs[1]), .err_discrep_in(errs[2]),
    .warn_vib_in(warns[0]), .warn_phase_in(warns[1]), .grant(grant),
    .rearm_req(rearm_req), .clear_req(clear_req), .err_cutoff(eo[0]),
    .err_sensor(eo[1]), .err_discrep(eo[2]), .warn_vib(wo[0]), .warn_phase(wo[1]),
    .override_active(override_active));
  ssr_partner #(.P(P)) u_op (.hclk(hclk), .rearm_pin(rearm_pin),
    .clear_pin(clear_pin), .override_pin(override_pin));
  // ----------------------------------------------------------------
  // Compare, bus and timing helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    dph_rd <= !w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    dph_rd <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    qm.push_back(m);
    qe.push_back(e & m);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic st(input logic [31:0] m, input logic [31:0] e);
    rd(8'h08, m, e);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge hclk);
  endtask
  task automatic setf(input logic [17:0] f);
    @(posedge hclk);
    freq <= f;
  endtask
  task automatic results;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Read data checked against the oldest note
  always @(posedge hclk) begin
    if (dph_rd && hreadyout) begin
      check(hrdata & qm[0], qe[0]);
      void'(qm.pop_front());
      void'(qe.pop_front());
    end
  end
  // Watchdog
  initial begin
    repeat (60000) @(posedge hclk);
    num_errors++;
    results();
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    cyc(16);
    hresetn <= 1'b1;
    rd(8'h00, 32'h3f, {26'h0, CTRL_RST});
    rd(8'h04, 32'h007f3fff, {9'h0, HYS_RST, 2'h0, THR_RST});
    rd(8'h20, 32'hffffffff, 32'h0);
    bus(1'b1, 8'h04, 32'h007f0000);
    cyc(1);
    rd(8'h04, 32'h007f3fff, {9'h0, HYS_MAX, 2'h0, THR_MIN});
    bus(1'b1, 8'h04, 32'h000a03e8);
    fvalid <= 1'b1;
    setf(18'd300 + 18'({$random(seed)} % 500));
    cyc(10);
    st(32'h4, 32'h0);
    while (rearm_req !== 1'b0) cyc(1);
    while (rearm_req !== 1'b1) cyc(1);
    n = 0;
    while (rearm_req === 1'b1) begin
      n++;
      cyc(1);
    end
    check(32'(n), 32'(500 * P));
    u_op.press(0, 50);
    cyc(10);
    st(32'h4, 32'h0);
    u_op.press(0, 150);
    cyc(8);
    st(32'hc, 32'h4);
    bus(1'b1, 8'h00, 32'h12);
    for (int i = 0; i < 5; i++) begin
      setf(ft[i]);
      cyc(6);
      st(32'hc, {29'h0, gt[i], 2'h0});
    end
    setf(18'd500);
    fvalid <= 1'b0;
    cyc(6);
    st(32'h4, 32'h0);
    fvalid <= 1'b1;
    cyc(6);
    st(32'hc, 32'h4);
    for (int i = 0; i < 3; i++) begin
      errs <= 3'h1 << i;
      cyc(1);
      errs <= 3'h0;
      cyc(6);
      st(32'he4, 32'h1 << (5 + i));
      while (clear_req !== 1'b1) cyc(1);
      u_op.press(1, 150);
      cyc(8);
      st(32'hf4, 32'h4);
    end
    // Clock enable low holds the grant although the speed is too high
    ce <= 1'b0;
    setf(18'd1500);
    cyc(6);
    check({31'h0, grant}, 32'h1);
    ce <= 1'b1;
    cyc(6);
    check({31'h0, grant}, 32'h0);
    bus(1'b1, 8'h00, 32'h1a);
    setf(18'd1500);
    cyc(6);
    u_op.flip(1'b1);
    cyc(8);
    st(32'h404, 32'h404);
    check({31'h0, override_active}, 32'h1);
    errs <= 3'h1;
    cyc(1);
    errs <= 3'h0;
    cyc(6);
    st(32'h424, 32'h424);
    u_op.press(1, 150);
    cyc(8);
    st(32'h434, 32'h404);
    errs <= 3'h2;
    cyc(4);
    u_op.flip(1'b0);
    cyc(8);
    st(32'h444, 32'h040);
    errs <= 3'h0;
    u_op.press(1, 150);
    u_op.flip(1'b1);
    cyc(1000 * P + 20);
    st(32'h400, 32'h0);
    u_op.flip(1'b0);
    bus(1'b1, 8'h00, 32'h16);
    cyc(6);
    u_op.flip(1'b1);
    cyc(8);
    st(32'h400, 32'h0);
    u_op.flip(1'b0);
    setf(18'd500);
    cyc(8);
    u_op.flip(1'b1);
    cyc(8);
    st(32'h404, 32'h404);
    u_op.flip(1'b0);
    // Long debounce: a 150 ms clear is refused, a 400 ms one clears
    bus(1'b1, 8'h00, 32'h32);
    errs <= 3'h4;
    cyc(1);
    errs <= 3'h0;
    u_op.press(1, 150);
    cyc(8);
    st(32'h80, 32'h80);
    check({29'h0, eo}, 32'h4);
    u_op.press(1, 400);
    cyc(8);
    st(32'h80, 32'h0);
    for (int i = 0; i < 4; i++) begin
      @(posedge hclk);
      warns <= 2'($random(seed));
      cyc(3);
      st(32'h300, {22'h0, warns, 8'h0});
      check({30'h0, wo}, {30'h0, warns});
    end
    results();
  end
endmodule // standstill_release_control_tb_top
`default_nettype wire
